// file: hdl/fp_decode_top.v
// floating coprocessor decode and accumulator block with apb registers
`timescale 1ns/100ps
`include "fp_decode_regs.vh"
module fp_decode_top (
  input  wire        clk_sys_in,
  input  wire        rst_b_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  output reg         trap_out,
  output reg  [15:0] trap_vector_out,
  output reg         mem_operand_req_out,
  output reg         double_mode_out,
  output reg         long_mode_out
);
  // ==========================================
  // state
  reg  [15:0] instr_q;
  reg  [15:0] status_q;
  reg  [3:0]  exception_code_register_q;
  reg  [2:0]  acc_sel_q;
  reg  [31:0] acc_lo_q;
  reg  [1:0]  limit_sel_q;
  reg         issue_q;
  wire        setup_w;
  wire        access_w;
  wire        wr_w;
  wire        rd_w;
  wire        is_fp;
  wire [2:0]  layout;
  wire [3:0]  op_sel;
  wire [1:0]  accumulator_select_field;
  wire [5:0]  source_specifier;
  wire        src_is_acc;
  wire        acc_illegal;
  wire        is_load_program_status_instr;
  wire        is_copy_condition_codes_instr;
  wire        is_set_single_instr;
  wire        is_set_double_instr;
  wire        is_set_short_integer_instr;
  wire        is_set_long_integer_instr;
  wire [63:0] acc_rd;
  reg         acc_wr_en;
  reg  [63:0] acc_wr_data;
  reg  [2:0]  acc_rd_sel;
  reg         trap_now;
  reg  [63:0] upper_magnitude_limit;
  reg  [63:0] lower_magnitude_limit;
  reg  [63:0] limit_sel_val;
  reg  [31:0] rdata_d;
  reg         rd_err;
  wire        precision_flipflop;
  wire        integer_width_flipflop;
  wire        interrupt_disable_bit;
  assign precision_flipflop     = status_q[`FPD_ST_PREC];
  assign integer_width_flipflop = status_q[`FPD_ST_IWIDTH];
  assign interrupt_disable_bit  = status_q[`FPD_ST_INT_DIS];
  assign setup_w  = psel_in && !penable_in;
  assign access_w = psel_in && penable_in && pready_out;
  assign wr_w     = access_w && pwrite_in;
  assign rd_w     = setup_w && !pwrite_in;
  // ==========================================
  // decoder and bank
  fp_field_decoder u_dec (
    .instr_in                        (instr_q),
    .is_fp_out                       (is_fp),
    .layout_out                      (layout),
    .floating_operation_selector_out (op_sel),
    .accumulator_select_field_out    (accumulator_select_field),
    .source_specifier_out            (source_specifier),
    .src_is_acc_out                  (src_is_acc),
    .acc_illegal_out                 (acc_illegal),
    .is_load_program_status_instr_out                    (is_load_program_status_instr),
    .is_copy_condition_codes_instr_out                     (is_copy_condition_codes_instr),
    .is_set_single_instr_out                     (is_set_single_instr),
    .is_set_double_instr_out                     (is_set_double_instr),
    .is_set_short_integer_instr_out                     (is_set_short_integer_instr),
    .is_set_long_integer_instr_out                     (is_set_long_integer_instr)
  );
  fp_accumulator_bank #(
    .NUM_ACC (6),
    .WIDTH   (64)
  ) u_bank (
    .clk_sys_in   (clk_sys_in),
    .rst_b_in     (rst_b_in),
    .wr_sel_in    (acc_sel_q),
    .wr_en_in     (acc_wr_en),
    .wr_single_in (!precision_flipflop),
    .wr_data_in   (acc_wr_data),
    .rd_sel_in    (acc_rd_sel),
    .rd_data_out  (acc_rd)
  );
  // ==========================================
  // magnitude limits follow the current format
  always @* begin
    if (precision_flipflop) begin
      upper_magnitude_limit = {1'b0, `FPD_EXP_UPPER, 55'h7fffffffffffff};
      lower_magnitude_limit = {1'b0, `FPD_EXP_LOWER, 55'h00000000000000};
    end else begin
      upper_magnitude_limit = {1'b0, `FPD_EXP_UPPER, 23'h7fffff, 32'h00000000};
      lower_magnitude_limit = {1'b0, `FPD_EXP_LOWER, 23'h000000, 32'h00000000};
    end
    case (limit_sel_q)
      2'h0:    limit_sel_val = upper_magnitude_limit;
      2'h1:    limit_sel_val = lower_magnitude_limit;
      default: limit_sel_val = 64'h0000000000000000;
    endcase
  end
  // ==========================================
  // accumulator path: software window, only 0-3 for transfers
  always @* begin
    acc_rd_sel  = acc_sel_q;
    acc_wr_data = {pwdata_in, acc_lo_q};
    // data transfer path limited to first four
    acc_wr_en   = wr_w && (paddr_in == `FPD_OFS_ACC_HI) && (acc_sel_q < 3'h4);
  end
  // ==========================================
  // trap decision at issue
  always @* begin
    // disable bit silences every trap
    trap_now = issue_q && is_fp && acc_illegal && !interrupt_disable_bit;
  end
  // ==========================================
  // read mux
  always @* begin
    rdata_d = 32'h00000000;
    rd_err  = 1'b0;
    case (paddr_in)
      `FPD_OFS_CTRL:      rdata_d = {31'h00000000, issue_q};
      `FPD_OFS_INSTR:     rdata_d = {16'h0000, instr_q};
      `FPD_OFS_STATUS:    rdata_d = {16'h0000, status_q};
      `FPD_OFS_EXC:       rdata_d = {28'h0000000, exception_code_register_q};
      `FPD_OFS_DECODE:    rdata_d = {8'h00, is_load_program_status_instr, is_copy_condition_codes_instr, is_set_single_instr, is_set_double_instr, is_set_short_integer_instr,
                                     is_set_long_integer_instr, acc_illegal, src_is_acc, source_specifier,
                                     accumulator_select_field, op_sel, layout, is_fp};
      `FPD_OFS_ACC_SEL:   rdata_d = {29'h00000000, acc_sel_q};
      // reads do not disturb the stored value
      `FPD_OFS_ACC_LO:    rdata_d = (acc_sel_q < 3'h4) ? acc_rd[31:0] : 32'h00000000;
      `FPD_OFS_ACC_HI:    rdata_d = (acc_sel_q < 3'h4) ? acc_rd[63:32] : 32'h00000000;
      `FPD_OFS_LIMIT_SEL: rdata_d = {30'h00000000, limit_sel_q};
      `FPD_OFS_LIMIT_LO:  rdata_d = limit_sel_val[31:0];
      `FPD_OFS_LIMIT_HI:  rdata_d = limit_sel_val[63:32];
      default:            rd_err  = 1'b1;
    endcase
  end
  // ==========================================
  // registers
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      instr_q                   <= 16'h0000;
      status_q                  <= `FPD_STATUS_RST;
      exception_code_register_q <= 4'h0;
      acc_sel_q                 <= 3'h0;
      acc_lo_q                  <= 32'h00000000;
      limit_sel_q               <= 2'h0;
      issue_q                   <= 1'b0;
      prdata_out                <= 32'h00000000;
      pready_out                <= 1'b0;
      pslverr_out               <= 1'b0;
      trap_out                  <= 1'b0;
      trap_vector_out           <= 16'h0000;
      mem_operand_req_out       <= 1'b0;
      double_mode_out           <= 1'b0;
      long_mode_out             <= 1'b0;
    end else begin
      // ready stands in the first access cycle; read data caught at setup
      // so that it already stands while ready is high
      pready_out  <= setup_w;
      prdata_out  <= rd_w ? rdata_d : prdata_out;
      pslverr_out <= setup_w && rd_err;
      issue_q     <= wr_w && (paddr_in == `FPD_OFS_CTRL) && pwdata_in[0];
      trap_out    <= trap_now;
      trap_vector_out <= trap_now ? `FPD_TRAP_VECTOR : trap_vector_out;
      // host does address arithmetic for memory operands; mode 0 never fetches
      mem_operand_req_out <= issue_q && is_fp && !acc_illegal &&
                             source_specifier[5:3] != 3'h0 &&
                             layout != `FPD_LAYOUT_FIVE;
      if (wr_w) begin
        case (paddr_in)
          `FPD_OFS_INSTR:     instr_q     <= pwdata_in[15:0];
          `FPD_OFS_ACC_SEL:   acc_sel_q   <= pwdata_in[2:0];
          `FPD_OFS_ACC_LO:    acc_lo_q    <= pwdata_in;
          `FPD_OFS_LIMIT_SEL: limit_sel_q <= pwdata_in[1:0];
          default:            acc_lo_q    <= acc_lo_q;
        endcase
      end
      // hardware set wins over software write
      if (trap_now) begin
        exception_code_register_q <= `FPD_EXC_ILLEGAL;
        status_q[`FPD_ST_ERR]     <= 1'b1;
      end else if (issue_q && is_fp && !acc_illegal) begin
        // flip-flops decide format, opcode carries none
        if (is_set_double_instr)      status_q[`FPD_ST_PREC]   <= 1'b1;
        else if (is_set_single_instr) status_q[`FPD_ST_PREC]   <= 1'b0;
        else if (is_set_long_integer_instr) status_q[`FPD_ST_IWIDTH] <= 1'b1;
        else if (is_set_short_integer_instr) status_q[`FPD_ST_IWIDTH] <= 1'b0;
      end else if (wr_w && paddr_in == `FPD_OFS_STATUS) begin
        status_q <= {pwdata_in[15:14], 2'h0, pwdata_in[11:5], 1'b0, pwdata_in[3:0]};
      end else if (wr_w && paddr_in == `FPD_OFS_EXC) begin
        exception_code_register_q <= pwdata_in[3:0];
      end
      double_mode_out <= precision_flipflop;
      long_mode_out   <= integer_width_flipflop;
    end
  end
endmodule

// file: shared/fp_decode_regs.vh
// constants for the floating coprocessor decode block
`ifndef FP_DECODE_REGS_VH
`define FP_DECODE_REGS_VH
// ==========================================
// register byte offsets
`define FPD_OFS_CTRL      12'h000
`define FPD_OFS_INSTR     12'h004
`define FPD_OFS_STATUS    12'h008
`define FPD_OFS_EXC       12'h00c
`define FPD_OFS_DECODE    12'h010
`define FPD_OFS_ACC_SEL   12'h014
`define FPD_OFS_ACC_LO    12'h018
`define FPD_OFS_ACC_HI    12'h01c
`define FPD_OFS_LIMIT_SEL 12'h020
`define FPD_OFS_LIMIT_LO  12'h024
`define FPD_OFS_LIMIT_HI  12'h028
// ==========================================
// status register bits
`define FPD_ST_ERR        15
`define FPD_ST_INT_DIS    14
`define FPD_ST_PREC       7
`define FPD_ST_IWIDTH     6
`define FPD_STATUS_RST    16'h0000
// ==========================================
// instruction encodings
`define FPD_TOP_OPCODE    4'hf
`define FPD_LOAD_PROGRAM_STATUS_INSTR_BASE    16'hf040
`define FPD_COPY_CONDITION_CODES_INSTR_CODE     16'hf000
`define FPD_SET_SINGLE_INSTR_CODE     16'hf001
`define FPD_SET_SHORT_INTEGER_INSTR_CODE     16'hf002
`define FPD_SET_DOUBLE_INSTR_CODE     16'hf009
`define FPD_SET_LONG_INTEGER_INSTR_CODE     16'hf00a
`define FPD_EXC_ILLEGAL   4'h2
`define FPD_TRAP_VECTOR   16'h00a4
// ==========================================
// layout codes
`define FPD_LAYOUT_NONE   3'h0
`define FPD_LAYOUT_ONE    3'h1
`define FPD_LAYOUT_TWO    3'h2
`define FPD_LAYOUT_THREE  3'h3
`define FPD_LAYOUT_FOUR   3'h4
`define FPD_LAYOUT_FIVE   3'h5
// ==========================================
// magnitude limit fields
`define FPD_EXP_UPPER     8'hff
`define FPD_EXP_LOWER     8'h01
`endif

// file: hdl/fp_accumulator_bank.v
// six-entry 64-bit accumulator bank
`timescale 1ns/100ps
module fp_accumulator_bank #(
  parameter NUM_ACC = 6,
  parameter WIDTH   = 64
) (
  input  wire             clk_sys_in,
  input  wire             rst_b_in,
  input  wire [2:0]       wr_sel_in,
  input  wire             wr_en_in,
  input  wire             wr_single_in,
  input  wire [WIDTH-1:0] wr_data_in,
  input  wire [2:0]       rd_sel_in,
  output wire [WIDTH-1:0] rd_data_out
);
  reg [WIDTH-1:0] acc_q [0:NUM_ACC-1];
  genvar i;
  // ==========================================
  // storage
  generate
    for (i = 0; i < NUM_ACC; i = i + 1) begin : g_acc
      always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          acc_q[i] <= {WIDTH{1'b0}};
        end else if (wr_en_in && (wr_sel_in == i)) begin
          // single data sits left-justified, low half cleared
          if (wr_single_in) begin
            acc_q[i] <= {wr_data_in[WIDTH-1:WIDTH/2], {(WIDTH/2){1'b0}}};
          end else begin
            acc_q[i] <= wr_data_in;
          end
        end
      end
    end
  endgenerate
  // reads are plain muxing, contents untouched
  assign rd_data_out = (rd_sel_in < NUM_ACC) ? acc_q[rd_sel_in] : {WIDTH{1'b0}};
endmodule

// file: hdl/fp_field_decoder.v
// combinational field and layout decoder
`timescale 1ns/100ps
`include "fp_decode_regs.vh"
module fp_field_decoder (
  input  wire [15:0] instr_in,
  output reg         is_fp_out,
  output reg  [2:0]  layout_out,
  output reg  [3:0]  floating_operation_selector_out,
  output reg  [1:0]  accumulator_select_field_out,
  output reg  [5:0]  source_specifier_out,
  output reg         src_is_acc_out,
  output reg         acc_illegal_out,
  output reg         is_load_program_status_instr_out,
  output reg         is_copy_condition_codes_instr_out,
  output reg         is_set_single_instr_out,
  output reg         is_set_double_instr_out,
  output reg         is_set_short_integer_instr_out,
  output reg         is_set_long_integer_instr_out
);
  reg [3:0] top_operation_code;
  always @* begin
    top_operation_code = instr_in[15:12];
    is_fp_out = (top_operation_code == `FPD_TOP_OPCODE);
    layout_out = `FPD_LAYOUT_NONE;
    floating_operation_selector_out = 4'h0;
    accumulator_select_field_out = instr_in[7:6];
    source_specifier_out = instr_in[5:0];
    src_is_acc_out = 1'b0;
    acc_illegal_out = 1'b0;
    is_load_program_status_instr_out = 1'b0;
    is_copy_condition_codes_instr_out = 1'b0;
    is_set_single_instr_out = 1'b0;
    is_set_double_instr_out = 1'b0;
    is_set_short_integer_instr_out = 1'b0;
    is_set_long_integer_instr_out = 1'b0;
    // exactly one layout per instruction
    if (is_fp_out) begin
      if (instr_in[11:8] != 4'h0) begin
        // layout one (three for selectors d and e): 4-bit selector, accumulator field, floating operand
        layout_out = `FPD_LAYOUT_ONE;
        floating_operation_selector_out = instr_in[11:8];
        if (instr_in[11:8] == 4'he || instr_in[11:8] == 4'hd) begin
          layout_out = `FPD_LAYOUT_THREE;
        end
      end else if (instr_in[7:6] != 2'h0) begin
        // layout two or four: 6-bit selector, one operand
        // upper selector bits are zero in this branch
        floating_operation_selector_out = instr_in[9:6];
        if (instr_in[7:6] == 2'h1) begin
          layout_out = `FPD_LAYOUT_FOUR;
          is_load_program_status_instr_out = ((instr_in & 16'hffc0) == `FPD_LOAD_PROGRAM_STATUS_INSTR_BASE);
        end else begin
          layout_out = `FPD_LAYOUT_TWO;
        end
      end else begin
        layout_out = `FPD_LAYOUT_FIVE;
        floating_operation_selector_out = instr_in[3:0];
        is_copy_condition_codes_instr_out = (instr_in == `FPD_COPY_CONDITION_CODES_INSTR_CODE);
        is_set_single_instr_out = (instr_in == `FPD_SET_SINGLE_INSTR_CODE);
        is_set_short_integer_instr_out = (instr_in == `FPD_SET_SHORT_INTEGER_INSTR_CODE);
        is_set_double_instr_out = (instr_in == `FPD_SET_DOUBLE_INSTR_CODE);
        is_set_long_integer_instr_out = (instr_in == `FPD_SET_LONG_INTEGER_INSTR_CODE);
      end
      // mode 0 on the floating operand of layouts one and two names an accumulator
      if ((layout_out == `FPD_LAYOUT_ONE || layout_out == `FPD_LAYOUT_TWO) &&
          instr_in[5:3] == 3'h0) begin
        src_is_acc_out = 1'b1;
        acc_illegal_out = (instr_in[2:0] > 3'h5);
      end
    end
  end
endmodule

// file: hdl/fp_unused_placeholder_never.v
// no logic here; the decode block lives in the other design files

// file: tb/fp_decode_top_props.sv
// port assertions for the decode block
`timescale 1ns/100ps
module fp_decode_props (
  input logic        clk_sys_in,
  input logic        rst_b_in,
  input logic        psel_in,
  input logic        penable_in,
  input logic        pwrite_in,
  input logic [11:0] paddr_in,
  input logic [31:0] pwdata_in,
  input logic [31:0] prdata_out,
  input logic        pready_out,
  input logic        pslverr_out,
  input logic        trap_out,
  input logic [15:0] trap_vector_out,
  input logic        mem_operand_req_out,
  input logic        double_mode_out,
  input logic        long_mode_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  logic wr_done;
  assign wr_done = psel_in && penable_in && pready_out && pwrite_in;
  // ========
  // bus and decode timing
  property p_ready_lat; psel_in && !penable_in |-> ##1 pready_out; endproperty
  a_ready_lat: assert property (p_ready_lat) else $error("ready late");
  property p_ready_idle; !psel_in |-> !pready_out; endproperty
  a_ready_idle: assert property (p_ready_idle) else $error("ready idle");
  property p_err_map;
    pslverr_out |-> pready_out && (paddr_in > 12'h028 || paddr_in[1:0] != 2'h0);
  endproperty
  a_err_map: assert property (p_err_map) else $error("bad error");
  property p_trap_pulse; trap_out |=> !trap_out; endproperty
  a_trap_pulse: assert property (p_trap_pulse) else $error("trap held");
  property p_trap_vec; trap_out |=> trap_vector_out == 16'h00a4; endproperty
  a_trap_vec: assert property (p_trap_vec) else $error("trap vector");
  property p_trap_src; trap_out |-> $past(wr_done, 2) || $past(wr_done, 3); endproperty
  a_trap_src: assert property (p_trap_src) else $error("stray trap");
  property p_no_mem; trap_out |-> !mem_operand_req_out; endproperty
  a_no_mem: assert property (p_no_mem) else $error("trap with fetch");
  property p_mem_src;
    mem_operand_req_out |-> $past(wr_done, 2) || $past(wr_done, 3);
  endproperty
  a_mem_src: assert property (p_mem_src) else $error("stray fetch");
  property p_dbl_src;
    $changed(double_mode_out) |-> $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3);
  endproperty
  a_dbl_src: assert property (p_dbl_src) else $error("double moved");
  property p_long_src;
    $changed(long_mode_out) |-> $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3);
  endproperty
  a_long_src: assert property (p_long_src) else $error("long moved");
  c_trap: cover property (trap_out);
  c_mem: cover property (mem_operand_req_out);
  c_err: cover property (pslverr_out);
endmodule
bind fp_decode_top fp_decode_props u_props (
  .clk_sys_in          (clk_sys_in),
  .rst_b_in            (rst_b_in),
  .psel_in             (psel_in),
  .penable_in          (penable_in),
  .pwrite_in           (pwrite_in),
  .paddr_in            (paddr_in),
  .pwdata_in           (pwdata_in),
  .prdata_out          (prdata_out),
  .pready_out          (pready_out),
  .pslverr_out         (pslverr_out),
  .trap_out            (trap_out),
  .trap_vector_out     (trap_vector_out),
  .mem_operand_req_out (mem_operand_req_out),
  .double_mode_out     (double_mode_out),
  .long_mode_out       (long_mode_out)
);

// file: tb/fp_host_model.sv
// apb host issuing coprocessor transfers
`timescale 1ns/100ps
module fp_host_model (
  input  logic        clk_sys_in,
  input  logic        pready_in,
  input  logic        pslverr_in,
  input  logic [31:0] prdata_in,
  output logic        psel_out,
  output logic        penable_out,
  output logic        pwrite_out,
  output logic [11:0] paddr_out,
  output logic [31:0] pwdata_out
);
  logic [31:0] rdata;
  logic        rerr;
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 12'h0;
    pwdata_out = 32'h0;
  end
  // ========
  // one transfer; operand words move only this way
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    psel_out    <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out  <= w;
    paddr_out   <= a;
    pwdata_out  <= d;
    @(posedge clk_sys_in);
    penable_out <= 1'b1;
    do @(posedge clk_sys_in); while (pready_in !== 1'b1);
    rdata = prdata_in;
    rerr  = pslverr_in;
    psel_out    <= 1'b0;
    penable_out <= 1'b0;
    // released lines toggle so stale values never look valid
    paddr_out   <= ~a;
    pwdata_out  <= ~d;
  endtask
endmodule

// file: tb/fp_instruction_decode_accumulators_test.sv
// self-checking bench for the decode block
`timescale 1ns/100ps
`include "fp_decode_regs.vh"
module fp_instruction_decode_accumulators_test;
  logic        clk_sys_in;
  logic        rst_b_in;
  logic        psel, penable, pwrite, pready, pslverr, trap, memreq, dbl, lng, ill;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, v, lo, hi;
  logic [15:0] tvec, ins;
  logic [15:0] sm [4];
  logic [11:0] ef;
  int          n_mismatch, compares, n_trap, n_mem, t0, m0;

  fp_decode_top u_dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .trap_out(trap),
    .trap_vector_out(tvec), .mem_operand_req_out(memreq), .double_mode_out(dbl),
    .long_mode_out(lng));
  fp_host_model u_host (.clk_sys_in(clk_sys_in), .pready_in(pready), .pslverr_in(pslverr),
    .prdata_in(prdata), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
    .paddr_out(paddr), .pwdata_out(pwdata));

  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    if (trap === 1'b1) n_trap++;
    if (memreq === 1'b1) n_mem++;
  end
  // ========
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // layout one unless the selector marks an accumulator-field layout
  function automatic logic [11:0] exp_fields(input logic [15:0] i);
    logic [2:0] l;
    l = i[11:8] == 4'hd || i[11:8] == 4'he ? `FPD_LAYOUT_THREE : `FPD_LAYOUT_ONE;
    return {l == `FPD_LAYOUT_ONE && i[5:3] == 3'h0, i[5:0], i[7:6], l};
  endfunction
  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task rd(input logic [11:0] a);
    u_host.xfer(1'b0, a, 32'h0);
    v = u_host.rdata;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d);
  endtask
  // decode acts a cycle after issue, pulses one later
  task issue(input logic [15:0] i);
    wr(`FPD_OFS_INSTR, {16'h0, i});
    wr(`FPD_OFS_CTRL, 32'h1);
    repeat (4) @(posedge clk_sys_in);
  endtask
  task give_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    give_verdict;
  end
  // ========
  // tests
  initial begin
    rst_b_in = 1'b0;
    seed = 32'hb850;
    n_mismatch = 0;
    compares = 0;
    n_trap = 0;
    n_mem = 0;
    sm = '{`FPD_SET_DOUBLE_INSTR_CODE, `FPD_SET_LONG_INTEGER_INSTR_CODE, `FPD_SET_SINGLE_INSTR_CODE, `FPD_SET_SHORT_INTEGER_INSTR_CODE};
    repeat (16) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    rd(`FPD_OFS_STATUS);
    chk("status", `FPD_STATUS_RST, v);
    wr(`FPD_OFS_STATUS, 32'h80);
    repeat (2) @(posedge clk_sys_in);
    chk("double", 1, dbl);
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      lo = seed;
      seed = lfsr(seed);
      hi = seed;
      wr(`FPD_OFS_ACC_SEL, k);
      wr(`FPD_OFS_ACC_LO, lo);
      wr(`FPD_OFS_ACC_HI, hi);
      repeat (2) begin
        rd(`FPD_OFS_ACC_HI);
        chk("acc_hi", k < 4 ? hi : 32'h0, v);
        rd(`FPD_OFS_ACC_LO);
        chk("acc_lo", k < 4 ? lo : 32'h0, v);
      end
    end
    wr(`FPD_OFS_STATUS, 32'h0);
    wr(`FPD_OFS_ACC_SEL, 32'h2);
    wr(`FPD_OFS_ACC_LO, lo);
    wr(`FPD_OFS_ACC_HI, hi);
    rd(`FPD_OFS_ACC_LO);
    chk("single_lo", 0, v);
    rd(`FPD_OFS_ACC_HI);
    chk("single_hi", hi, v);
    $display("test accumulators done");
    for (int i = 0; i < 4; i++) begin
      issue(sm[i]);
      chk("double", i < 2, dbl);
      chk("long", i == 1 || i == 2, lng);
      rd(`FPD_OFS_DECODE);
      chk("layout", 5, v[3:1]);
    end
    issue(`FPD_COPY_CONDITION_CODES_INSTR_CODE);
    rd(`FPD_OFS_DECODE);
    chk("copy_condition_codes_instr", {1'b1, `FPD_LAYOUT_FIVE, 1'b1}, {v[22], v[3:0]});
    issue(`FPD_LOAD_PROGRAM_STATUS_INSTR_BASE + 16'h1f);
    rd(`FPD_OFS_DECODE);
    chk("load_program_status_instr", {1'b1, 6'h1f, `FPD_LAYOUT_FOUR}, {v[23], v[15:10], v[3:1]});
    issue(16'h7406);
    rd(`FPD_OFS_DECODE);
    chk("isfp", 0, v[0]);
    $display("test modes done");
    // first two are illegal accumulator corners, third an accumulator-field layout
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      ins = i == 0 ? 16'hf406 : i == 1 ? 16'hf4c7 : i == 2 ? 16'hfdc6 : 16'hf400 | seed[7:0];
      ef = exp_fields(ins);
      ill = ef[11] && ins[2:0] > 3'h5;
      t0 = n_trap;
      m0 = n_mem;
      issue(ins);
      chk("trap", ill, n_trap - t0);
      chk("memreq", ins[5:3] != 3'h0, n_mem - m0);
      rd(`FPD_OFS_DECODE);
      chk("fields", ef, {v[16], v[15:8], v[3:1]});
      if (ill) begin
        rd(`FPD_OFS_EXC);
        chk("exc", `FPD_EXC_ILLEGAL, v);
        chk("vector", `FPD_TRAP_VECTOR, tvec);
      end
    end
    wr(`FPD_OFS_STATUS, 32'h4000);
    t0 = n_trap;
    issue(16'hf406);
    chk("masked", 0, n_trap - t0);
    $display("test traps done");
    rd(12'h100);
    chk("unmapped_err", 1, u_host.rerr);
    chk("unmapped", 0, v);
    wr(`FPD_OFS_LIMIT_SEL, 32'h0);
    rd(`FPD_OFS_LIMIT_HI);
    chk("upper", 32'h7fffffff, v);
    wr(`FPD_OFS_STATUS, 32'h4080);
    rd(`FPD_OFS_LIMIT_LO);
    chk("upper_lo", 32'hffffffff, v);
    wr(`FPD_OFS_LIMIT_SEL, 32'h1);
    rd(`FPD_OFS_LIMIT_HI);
    chk("lower", 32'h00800000, v);
    $display("test limits done");
    give_verdict;
  end
endmodule
